/* hdl/wdr_pkg.sv */
// Constants, register map and types of the watchdog reset timer
// Behaviour
// (R1) Cascaded hidden prescaler then 8-bit timeout counter
// (R2) Prescaler auto-reloads selected divisor at zero
// (R3) Select 000b=256 doubling to 111b=32768
// (R4) Timeout decrements when prescaler reaches zero
// (R5) Reset request when both zero and enabled
// (R6) Clear-then-set reload bit within 32 clocks reloads
// (R7) Other reload-bit writes change nothing
// (R8) Reload bit write-only, reads zero
// (R9) Reload handshake works regardless of enable
// (R10) Disabled: counters hold, no reset
// (R11) Any system reset leaves watchdog disabled
// (R12) Count write stores reload; read returns count
// (R13) Keeps counting in Idle; reset after Idle
// (R14) Software disables before long Idle periods
// (R15) Software rechecks count and repeats handshake
// (R16) Control bits 7:5 read zero
// (R17) Period equals divisor times reload plus one; the logic expires after at most divisor times reload, or one divisor for reload zero
// (R18) Reset request is registered one-cycle pulse
package wdr_pkg;
	localparam int WDR_ADDR_W = 8;
	localparam logic [7:0] WDR_OFS_CONTROL = 8'hAC;
	localparam logic [7:0] WDR_OFS_COUNT = 8'hAD;
	localparam int WDR_BIT_RELOAD = 0;
	localparam int WDR_BIT_ENABLE = 1;
	localparam int WDR_SEL_LSB = 2;
	localparam int WDR_SEL_MSB = 4;
	localparam logic [7:0] WDR_CONTROL_RST = 8'h00;
	localparam logic [7:0] WDR_COUNT_RST = 8'h00;
	localparam logic [15:0] WDR_PRE_BASE = 16'h0100;
	localparam int WDR_PRE_W = 16;
	localparam int WDR_CLK_MHZ = 40;
	localparam int WDR_CORE_MHZ = 40;
	localparam int WDR_HS_WINDOW_CORE = 32;
	localparam int WDR_HS_WINDOW_CYC = (WDR_HS_WINDOW_CORE * WDR_CLK_MHZ) / WDR_CORE_MHZ;

	typedef struct packed {
		logic [2:0] prescale_select;
		logic watchdog_enable;
	} wdr_ctrl_t;

	typedef struct packed {
		logic reload_strobe_wr;
		logic reload_strobe_val;
		logic count_wr;
		logic [7:0] count_data;
	} wdr_wr_t;

	function automatic logic [15:0] wdr_divisor(input logic [2:0] sel);
		return WDR_PRE_BASE << sel;
	endfunction
endpackage

/* hdl/wdr_prescaler.sv */
// Hidden prescale count-down stage of the watchdog
`timescale 1ns/1ps
`default_nettype none
module wdr_prescaler import wdr_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [2:0] prescale_select,
	output logic tick,
	output logic at_zero
);
	logic [WDR_PRE_W-1:0] cnt_r;
	logic [WDR_PRE_W-1:0] cnt_nxt;

	assign at_zero = cnt_r == '0;
	assign tick = run && cnt_r == 16'h0001;

	always_comb begin
		cnt_nxt = cnt_r;
		if (run) begin
			if (at_zero) begin
				cnt_nxt = wdr_divisor(prescale_select) - 16'h0001; // see (R2) (R3)
			end else begin
				cnt_nxt = cnt_r - 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt; // see (R10)
		end
	end
endmodule
`default_nettype wire

/* hdl/wdr_top.sv */
// Top of the watchdog reset timer with reload handshake and timeout
`timescale 1ns/1ps
`default_nettype none
module wdr_top import wdr_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic idle_mode,
	output logic wdt_reset_req
);
	typedef enum logic [1:0] {
		WDR_HS_IDLE = 2'b01,
		WDR_HS_ARMED = 2'b10
	} wdr_hs_t;

	wdr_ctrl_t ctrl;
	wdr_wr_t wr;
	logic [7:0] count_r;
	logic [7:0] reload_r;
	logic [5:0] win_r;
	wdr_hs_t hs_r;
	logic reload_go;
	logic pre_tick;
	logic pre_zero;
	logic pending_r;
	logic fire_r;
	logic expired;
	logic hit_ctl_q;

	// ==========================================
	// Register bus
	wdr_wb_regs u_regs (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.count_value(count_r),
		.ctrl(ctrl),
		.wr(wr)
	);

	// ==========================================
	// Prescale stage
	wdr_prescaler u_pre (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.run(ctrl.watchdog_enable), // see (R1) (R10) (R13)
		.prescale_select(ctrl.prescale_select),
		.tick(pre_tick),
		.at_zero(pre_zero)
	);

	// ==========================================
	// Reload handshake
	assign reload_go = hs_r == WDR_HS_ARMED && wr.reload_strobe_wr && wr.reload_strobe_val
		&& win_r != '0; // see (R6) (R9)

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			hs_r <= WDR_HS_IDLE;
			win_r <= '0;
		end else begin
			case (hs_r)
				WDR_HS_IDLE: begin
					if (wr.reload_strobe_wr && !wr.reload_strobe_val) begin
						hs_r <= WDR_HS_ARMED;
						win_r <= 6'(WDR_HS_WINDOW_CYC);
					end
				end
				WDR_HS_ARMED: begin
					if (wr.reload_strobe_wr && !wr.reload_strobe_val) begin
						win_r <= 6'(WDR_HS_WINDOW_CYC);
					end else if (wr.reload_strobe_wr || win_r == 6'h01) begin
						hs_r <= WDR_HS_IDLE; // see (R7)
						win_r <= '0;
					end else begin
						win_r <= win_r - 6'h01;
					end
				end
				default: begin
					hs_r <= WDR_HS_IDLE;
					win_r <= '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			reload_r <= WDR_COUNT_RST;
		end else if (wr.count_wr) begin
			reload_r <= wr.count_data; // see (R12)
		end
	end

	// ==========================================
	// Timeout counter
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			count_r <= WDR_COUNT_RST;
		end else if (reload_go) begin
			count_r <= reload_r; // see (R6)
		end else if (pre_tick && count_r != 8'h00) begin
			count_r <= count_r - 8'h01; // see (R4) (R17)
		end
	end

	// ==========================================
	// Reset request
	assign expired = ctrl.watchdog_enable && count_r == 8'h00 && pre_zero && !reload_go; // see (R5)

	// Held through Idle, released on exit
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pending_r <= 1'b0;
		end else if (fire_r) begin
			pending_r <= 1'b0;
		end else if (expired) begin
			pending_r <= 1'b1; // see (R13)
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			fire_r <= 1'b0;
		end else begin
			fire_r <= pending_r && !idle_mode && !fire_r && ctrl.watchdog_enable; // see (R18) (R10)
		end
	end

	assign wdt_reset_req = fire_r;

	// ==========================================
	// Checks
	AST_PULSE_ONE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wdt_reset_req |=> !wdt_reset_req) else $error("reset pulse longer than one cycle"); // see (R18)
	AST_NO_RESET_DISABLED: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!ctrl.watchdog_enable |-> !wdt_reset_req) else $error("reset while disabled"); // see (R10)
	AST_HOLD_DISABLED: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!ctrl.watchdog_enable && !reload_go |=> count_r == $past(count_r))
		else $error("count moved while disabled"); // see (R10)
	AST_RELOAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reload_go |=> count_r == $past(reload_r)) else $error("reload not applied"); // see (R6)
	AST_DECR: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pre_tick && !reload_go && count_r != 8'h00 |=> count_r == $past(count_r) - 8'h01)
		else $error("timeout not decremented"); // see (R4)
	AST_NO_PAIR: assert property (@(posedge clk_sys) disable iff (!rst_n)
		hs_r == WDR_HS_IDLE |-> !reload_go) else $error("reload without clear"); // see (R7)
	AST_EXPIRE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		expired && !idle_mode && !pending_r |=> ##1 wdt_reset_req)
		else $error("expiry not reported"); // see (R5)
	AST_READ_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wb_ack_o && !wb_we_i && $past(hit_ctl_q) |-> wb_dat_o[7:5] == 3'b000 && !wb_dat_o[0])
		else $error("reserved or reload bit read nonzero"); // see (R8) (R16)
	AST_COUNT_WR: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr.count_wr && !reload_go && !pre_tick |=> count_r == $past(count_r))
		else $error("count write changed count"); // see (R12)

	assign hit_ctl_q = wb_adr_i == {22'h0, WDR_OFS_CONTROL, 2'b00};

	COV_RELOAD: cover property (@(posedge clk_sys) reload_go);
	COV_FIRE: cover property (@(posedge clk_sys) wdt_reset_req);
	COV_IDLE_HOLD: cover property (@(posedge clk_sys) pending_r && idle_mode);
endmodule
`default_nettype wire

/* hdl/wdr_wb_regs.sv */
// Wishbone classic slave for the watchdog registers
`timescale 1ns/1ps
`default_nettype none
module wdr_wb_regs import wdr_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [7:0] count_value,
	output wdr_ctrl_t ctrl,
	output wdr_wr_t wr
);
	logic ack_r;
	logic [31:0] dat_r;
	wdr_ctrl_t ctrl_r;
	logic req;
	logic hit_ctl;
	logic hit_cnt;
	logic lane0;

	assign req = wb_cyc_i && wb_stb_i && !ack_r;
	assign hit_ctl = wb_adr_i == {22'h0, WDR_OFS_CONTROL, 2'b00};
	assign hit_cnt = wb_adr_i == {22'h0, WDR_OFS_COUNT, 2'b00};
	assign lane0 = wb_sel_i[0];
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign ctrl = ctrl_r;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req;
		end
	end

	// Unmapped reads return zero, writes dropped
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dat_r <= 32'h0000_0000;
		end else if (req && !wb_we_i) begin
			if (hit_ctl) begin
				dat_r <= {27'h0, ctrl_r.prescale_select, ctrl_r.watchdog_enable, 1'b0}; // see (R8) (R16)
			end else if (hit_cnt) begin
				dat_r <= {24'h0, count_value}; // see (R12)
			end else begin
				dat_r <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ctrl_r <= '0; // see (R11)
		end else if (req && wb_we_i && hit_ctl && lane0) begin
			ctrl_r.prescale_select <= wb_dat_i[WDR_SEL_MSB:WDR_SEL_LSB];
			ctrl_r.watchdog_enable <= wb_dat_i[WDR_BIT_ENABLE];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wr <= '0;
		end else begin
			wr.reload_strobe_wr <= req && wb_we_i && hit_ctl && lane0;
			wr.reload_strobe_val <= wb_dat_i[WDR_BIT_RELOAD];
			wr.count_wr <= req && wb_we_i && hit_cnt && lane0;
			wr.count_data <= wb_dat_i[7:0];
		end
	end
endmodule
`default_nettype wire

/* tb/wdr_top_bench.sv */
// Self-checking bench of the watchdog reset timer
`timescale 1ns/1ps
`default_nettype none
module wdr_top_bench import wdr_pkg::*; ;
	localparam logic [7:0] C = WDR_OFS_CONTROL;
	localparam logic [7:0] K = WDR_OFS_COUNT;
	logic clk_sys = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, idle = 1'b0;
	logic [31:0] adr = 32'h0, dat = 32'h0, rdat;
	logic [3:0] sel = 4'h0;
	logic ack, req, req_d = 1'b0;
	logic [15:0] lf = 16'h212A;
	logic [7:0] q, a;
	int n_errors = 0, n_checks = 0, n_pulse = 0, cyc_n = 0, t0, d, p, r;

	wdr_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .idle_mode(idle), .wdt_reset_req(req));

	always #12.5 clk_sys = ~clk_sys;

	// ==========================================
	// Helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic int divisor(input int s);
		return 256 << s;
	endfunction

	task automatic finish_test();
		if (n_errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] o, input logic [7:0] v);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hF;
		adr <= {22'h0, o, 2'h0};
		dat <= {24'h0, v};
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) n_errors++;
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_sys);
	endtask

	// Clear-then-set of the reload bit, keeping the other fields
	task automatic hs(input logic [7:0] c);
		bus(1'b1, C, c);
		bus(1'b1, C, c | 8'h01);
	endtask

	task automatic wait_change();
		logic [7:0] v;
		bus(1'b0, K, 8'h00);
		v = q;
		do bus(1'b0, K, 8'h00); while (q === v);
	endtask

	// Pulse monitor and hang guard
	always @(posedge clk_sys) begin
		cyc_n++;
		req_d <= req;
		if (req === 1'b1) n_pulse++;
		if (req === 1'b1 && req_d === 1'b1) chk(32'h1, 32'h0);
		if (cyc_n == 90000) begin
			n_errors++;
			finish_test();
		end
	end

	// ==========================================
	// Main sequence
	initial begin
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		bus(1'b0, C, 8'h00);
		chk(q, 8'h00);
		bus(1'b0, K, 8'h00);
		chk(q, 8'h00);
		bus(1'b0, 8'h10, 8'h00);
		chk(q, 8'h00);
		a = lf[7:0] | 8'h01;
		lf = lfsr(lf);
		bus(1'b1, K, a);
		bus(1'b0, K, 8'h00);
		chk(q, 8'h00);
		bus(1'b1, C, 8'h01);
		bus(1'b0, K, 8'h00);
		chk(q, 8'h00);
		bus(1'b1, C, 8'h00);
		repeat (40) @(posedge clk_sys);
		bus(1'b1, C, 8'h01);
		bus(1'b0, K, 8'h00);
		chk(q, 8'h00);
		hs(8'h00);
		bus(1'b0, K, 8'h00);
		chk(q, a);
		bus(1'b0, C, 8'h00);
		chk(q, 8'h00);
		for (int s = 0; s < 7; s++) begin
			bus(1'b1, K, 8'hFF);
			hs({3'h0, 3'(s), 2'h2});
			wait_change();
			t0 = cyc_n;
			wait_change();
			d = cyc_n - t0;
			chk((d >= divisor(s) - 4 && d <= divisor(s) + 4) ? divisor(s) : d, divisor(s));
		end
		bus(1'b1, C, 8'h1C);
		bus(1'b0, C, 8'h00);
		chk(q, 8'h1C);
		a = q;
		bus(1'b0, K, 8'h00);
		a = q;
		p = n_pulse;
		idle <= 1'b1;
		repeat (600) @(posedge clk_sys);
		idle <= 1'b0;
		bus(1'b0, K, 8'h00);
		chk(q, a);
		chk(n_pulse, p);
		// Fresh prescaler so the timeout starts from a known phase
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		r = int'(lf[2:0]) + 1;
		bus(1'b1, K, 8'(r));
		hs(8'h00);
		bus(1'b1, C, 8'h02);
		t0 = cyc_n;
		p = n_pulse;
		while (n_pulse == p && cyc_n - t0 < 256 * (r + 2)) @(posedge clk_sys);
		d = cyc_n - t0;
		chk((d >= 256 * r && d <= 256 * (r + 1) + 8) ? 256 * (r + 1) : d, 256 * (r + 1));
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		bus(1'b0, C, 8'h00);
		chk(q, 8'h00);
		bus(1'b1, K, 8'h01);
		hs(8'h00);
		idle <= 1'b1;
		bus(1'b1, C, 8'h02);
		p = n_pulse;
		repeat (800) @(posedge clk_sys);
		chk(n_pulse, p);
		bus(1'b0, K, 8'h00);
		chk(q, 8'h00);
		idle <= 1'b0;
		repeat (6) @(posedge clk_sys);
		chk(n_pulse, p + 1);
		finish_test();
	end
endmodule
`default_nettype wire
